// File: pkg/etf_pkg.sv
// constants, types and helpers shared by the e1 transmit format block
`default_nettype none
package etf_pkg;

  // ==========================================================
  // sizes and clock
  localparam int NCH      = 8;
  localparam int CLK_MHZ  = 200;
  localparam int CNT_W    = 12;
  localparam int SYNC_W   = 3 * NCH + 4;

  // ==========================================================
  // positions of the synchronised inputs inside the sync vector
  localparam int SI_TX_LINE_CLOCK  = 0;
  localparam int SI_TX_POSITIVE_DATA  = NCH;
  localparam int SI_TX_NEGATIVE_DATA  = 2 * NCH;
  localparam int SI_MREF  = 3 * NCH;
  localparam int SI_GLOBAL_TX_OUTPUT_CONTROL  = 3 * NCH + 1;
  localparam int SI_CODE  = 3 * NCH + 2;
  localparam int SI_IMP   = 3 * NCH + 3;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_SEL   = 8'h10;
  localparam logic [7:0] IDX_LINE_DATA  = 8'h11;
  localparam logic [7:0] IDX_OUT_DIS    = 8'h12;
  localparam logic [7:0] IDX_STATUS     = 8'h13;
  localparam logic [7:0] IDX_CHAN_STATE = 8'h14;

  // field positions and reset values
  localparam int CSEL_CH_LSB = 0;
  localparam int CSEL_CH_W   = 3;
  localparam int CSEL_HDB3   = 4;
  localparam int LDATA_W     = 4;
  localparam int ST_READY    = 0;
  localparam int ST_REF_ACT  = 1;
  localparam logic [7:0]         CSEL_RST   = 8'h00;
  localparam logic [LDATA_W-1:0] LDATA_RST  = 4'h0;
  localparam logic [7:0]         OUTDIS_RST = 8'h00;

  // line setting codes used for the hardware-mode impedance pin
  localparam logic [LDATA_W-1:0] LINE_75  = 4'h0;
  localparam logic [LDATA_W-1:0] LINE_120 = 4'h1;

  // ==========================================================
  // timing
  localparam int IDLE_NS      = 12000;
  localparam int IDLE_CYC     = (IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_IDLE_NS  = 1000;
  localparam int REF_IDLE_CYC = (REF_IDLE_NS * CLK_MHZ) / 1000;
  localparam int PD_REF_CYC   = 140;
  localparam int UBS_TX_LINE_CLOCK_CYC = 16;
  localparam int AOS_REF_CYC  = 16;
  localparam int CAL_MS       = 30;
  localparam int CAL_CYC      = CAL_MS * 1000 * CLK_MHZ;
  localparam int CAL_W        = 23;

  typedef enum logic [1:0] {
    MODE_BIPOLAR,
    MODE_UNIPOLAR,
    MODE_RZ
  } etf_mode_t;

  // saturating increment shared by the 12-bit edge and cycle counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    return (v == {CNT_W{1'b1}}) ? v : v + 12'h001;
  endfunction

endpackage
`default_nettype wire

// File: hw/etf_in_sync.sv
// three-flop input synchroniser with agreement filter and edge pulses
`default_nettype none
module etf_in_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic [W-1:0] lvl_d, rise_d, fall_d;

  // ==========================================================
  // a change counts only once the second and third stage agree
  always_comb begin
    lvl_d  = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    rise_d = lvl_d & ~lvl_q;
    fall_d = ~lvl_d & lvl_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      s1_q   <= din_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign lvl_o  = lvl_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule
`default_nettype wire

// File: hw/etf_tx_format.sv
// eight-channel e1 transmit format control with wishbone registers
`default_nettype none
module etf_tx_format
  import etf_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 host_mode_i,
  input  wire logic [NCH-1:0]       tx_line_clock_i,
  input  wire logic [NCH-1:0]       tx_positive_data_i,
  input  wire logic [NCH-1:0]       tx_negative_data_i,
  input  wire logic                 ref_clock_i,
  input  wire logic                 global_tx_output_control_i,
  input  wire logic                 line_code_select_i,
  input  wire logic                 impedance_select_i,
  output logic      [NCH-1:0]       line_out_a_o,
  output logic      [NCH-1:0]       line_out_b_o,
  output logic      [NCH-1:0]       line_out_en_n_o,
  output logic      [4*NCH-1:0]     line_setting_code_o,
  output logic                      ready_o,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [9:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o
);

  // ==========================================================
  // input synchronisers
  logic [SYNC_W-1:0] lvl, rise, fall;

  etf_in_sync #(.W(SYNC_W)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .din_i  ({impedance_select_i, line_code_select_i,
              global_tx_output_control_i, ref_clock_i,
              tx_negative_data_i, tx_positive_data_i, tx_line_clock_i}),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  logic ref_rise, global_tx_output_control, hdb3_sel;
  assign ref_rise = rise[SI_MREF];
  assign global_tx_output_control     = lvl[SI_GLOBAL_TX_OUTPUT_CONTROL];

  // ==========================================================
  // power-up calibration and reference activity
  logic [CAL_W-1:0] por_cnt_q, por_cnt_d;
  logic             ready_q, ready_d;
  logic [CNT_W-1:0] ref_idle_q, ref_idle_d;
  logic             ref_act_q, ref_act_d;

  always_comb begin
    por_cnt_d  = por_cnt_q;
    ready_d    = ready_q;
    if (!ready_q) begin
      if (por_cnt_q == CAL_W'(CAL_CYCLES - 1)) begin
        ready_d = 1'b1;
      end else begin
        por_cnt_d = por_cnt_q + 23'h000001;
      end
    end
    ref_idle_d = ref_rise ? '0 : sat_inc(ref_idle_q);
    ref_act_d  = (ref_idle_d < CNT_W'(REF_IDLE_CYC));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt_q  <= '0;
      ready_q    <= 1'b0;
      ref_idle_q <= '0;
      ref_act_q  <= 1'b0;
    end else begin
      por_cnt_q  <= por_cnt_d;
      ready_q    <= ready_d;
      ref_idle_q <= ref_idle_d;
      ref_act_q  <= ref_act_d;
    end
  end

  // ==========================================================
  // wishbone register file
  logic [7:0]         csel_q, csel_d;
  logic [LDATA_W-1:0] ldata_q [NCH];
  logic [LDATA_W-1:0] ldata_d [NCH];
  logic [7:0]         outdis_q, outdis_d;
  logic               ack_q, ack_d;
  logic [31:0]        dat_q, dat_d;
  logic [NCH-1:0]     uni_mask, pd_mask;
  logic               req, go, wr;
  logic [7:0]         idx;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  // answer waits for a reference edge; without a reference it
  // answers at once so a dead reference cannot hang the bus
  assign go  = req & (ref_rise | ~ref_act_q);
  assign wr  = go & wb_we_i & wb_sel_i[0] & ready_q;
  assign hdb3_sel = host_mode_i ? csel_q[CSEL_HDB3]
                                : lvl[SI_CODE];

  always_comb begin
    csel_d   = csel_q;
    ldata_d  = ldata_q;
    outdis_d = outdis_q;
    ack_d    = go;
    dat_d    = dat_q;
    if (wr) begin
      case (idx)
        IDX_CHAN_SEL: csel_d = wb_dat_i[7:0];
        IDX_LINE_DATA:
          ldata_d[csel_q[CSEL_CH_LSB +: CSEL_CH_W]] =
            wb_dat_i[LDATA_W-1:0];
        IDX_OUT_DIS: outdis_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (go && !wb_we_i) begin
      case (idx)
        IDX_CHAN_SEL: dat_d = {24'h000000, csel_q};
        IDX_LINE_DATA:
          dat_d = {28'h0000000, ldata_q[csel_q[CSEL_CH_LSB +: CSEL_CH_W]]};
        IDX_OUT_DIS: dat_d = {24'h000000, outdis_q};
        IDX_STATUS: dat_d = {30'h0, ref_act_q, ready_q};
        IDX_CHAN_STATE: dat_d = {16'h0000, pd_mask, uni_mask};
        default: dat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ready_q) begin
      csel_q   <= CSEL_RST;
      ldata_q  <= '{default: LDATA_RST};
      outdis_q <= OUTDIS_RST;
    end else begin
      csel_q   <= csel_d;
      ldata_q  <= ldata_d;
      outdis_q <= outdis_d;
    end
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ==========================================================
  // per-channel mode tracking, encoding and line outputs
  etf_mode_t        mode_q [NCH];
  etf_mode_t        mode_d [NCH];
  logic [CNT_W-1:0] hi_cnt_q [NCH], hi_cnt_d [NCH];
  logic [CNT_W-1:0] lo_cnt_q [NCH], lo_cnt_d [NCH];
  logic [CNT_W-1:0] hi_ref_q [NCH], hi_ref_d [NCH];
  logic [CNT_W-1:0] lo_ref_q [NCH], lo_ref_d [NCH];
  logic [CNT_W-1:0] ubs_q [NCH], ubs_d [NCH];
  // four-symbol hdb3 window: {violation, pulse} per slot, slot 3 oldest
  logic [7:0]       enc_q [NCH], enc_d [NCH];
  logic [NCH-1:0]   par_q, par_d, pol_q, pol_d, aos_pol_q, aos_pol_d;
  logic [NCH-1:0]   pd_q, pd_d, aos_q, aos_d;
  logic [NCH-1:0]   a_q, a_d, b_q, b_d, oen_q, oen_d;
  logic [4*NCH-1:0] set_q, set_d;

  always_comb begin
    logic tx_line_clock;
    logic [1:0] out_e;
    logic polv;
    tx_line_clock  = 1'b0;
    out_e = 2'b00;
    polv  = 1'b0;
    mode_d = mode_q;
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    hi_ref_d = hi_ref_q;
    lo_ref_d = lo_ref_q;
    ubs_d = ubs_q;
    enc_d = enc_q;
    par_d = par_q;
    pol_d = pol_q;
    aos_pol_d = aos_pol_q;
    a_d = a_q;
    b_d = b_q;
    for (int c = 0; c < NCH; c++) begin
      tx_line_clock = lvl[SI_TX_LINE_CLOCK + c];
      if (tx_line_clock) begin
        hi_cnt_d[c] = sat_inc(hi_cnt_q[c]);
        lo_cnt_d[c] = '0;
        lo_ref_d[c] = '0;
        if (ref_rise) hi_ref_d[c] = sat_inc(hi_ref_q[c]);
      end else begin
        lo_cnt_d[c] = sat_inc(lo_cnt_q[c]);
        hi_cnt_d[c] = '0;
        hi_ref_d[c] = '0;
        if (ref_rise) lo_ref_d[c] = sat_inc(lo_ref_q[c]);
      end
      if (fall[SI_TX_LINE_CLOCK + c]) begin
        if (lvl[SI_TX_NEGATIVE_DATA + c]) begin
          ubs_d[c] = sat_inc(ubs_q[c]);
        end else begin
          ubs_d[c] = '0;
        end
      end
      // mode selection
      if (!ref_act_q && tx_line_clock && hi_cnt_q[c] >= CNT_W'(IDLE_CYC)) begin
        mode_d[c] = MODE_RZ;
      end else begin
        case (mode_q[c])
          MODE_RZ: if (ref_act_q) mode_d[c] = MODE_BIPOLAR;
          MODE_BIPOLAR:
            if (ubs_d[c] > CNT_W'(UBS_TX_LINE_CLOCK_CYC)) mode_d[c] = MODE_UNIPOLAR;
          MODE_UNIPOLAR:
            if (fall[SI_TX_LINE_CLOCK + c] && !lvl[SI_TX_NEGATIVE_DATA + c])
              mode_d[c] = MODE_BIPOLAR;
          default: mode_d[c] = MODE_BIPOLAR;
        endcase
      end
      // line data
      if (aos_q[c]) begin
        if (ref_rise) begin
          aos_pol_d[c] = ~aos_pol_q[c];
          a_d[c] = ~aos_pol_q[c];
          b_d[c] = aos_pol_q[c];
        end
      end else if (mode_q[c] == MODE_RZ) begin
        a_d[c] = lvl[SI_TX_POSITIVE_DATA + c];
        b_d[c] = lvl[SI_TX_NEGATIVE_DATA + c];
      end else if (fall[SI_TX_LINE_CLOCK + c]) begin
        if (mode_q[c] == MODE_BIPOLAR) begin
          a_d[c] = lvl[SI_TX_POSITIVE_DATA + c];
          b_d[c] = lvl[SI_TX_NEGATIVE_DATA + c];
        end else begin
          out_e = enc_q[c][7:6];
          enc_d[c] = {enc_q[c][5:0], 1'b0, lvl[SI_TX_POSITIVE_DATA + c]};
          if (lvl[SI_TX_POSITIVE_DATA + c]) par_d[c] = ~par_q[c];
          // four zeros in a row become 000V or B00V
          if (hdb3_sel && !lvl[SI_TX_POSITIVE_DATA + c] &&
              !enc_q[c][0] && !enc_q[c][2] && !enc_q[c][4]) begin
            enc_d[c][1:0] = 2'b11;
            if (!par_q[c]) enc_d[c][7:6] = 2'b01;
            par_d[c] = 1'b0;
          end
          polv = out_e[1] ? pol_q[c] : ~pol_q[c];
          if (out_e[0]) pol_d[c] = polv;
          a_d[c] = out_e[0] & polv;
          b_d[c] = out_e[0] & ~polv;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pd_d[c] = ~lvl[SI_TX_LINE_CLOCK + c] &
                ((lo_cnt_q[c] >= CNT_W'(IDLE_CYC)) |
                 (lo_ref_q[c] >= CNT_W'(PD_REF_CYC)));
      aos_d[c] = ~host_mode_i & ref_act_q & lvl[SI_TX_LINE_CLOCK + c] &
                 (hi_ref_q[c] > CNT_W'(AOS_REF_CYC));
      // the global pin only gates the drivers, never the register
      oen_d[c] = ~ready_q | pd_q[c] | global_tx_output_control |
                 (host_mode_i & outdis_q[c]);
      set_d[4*c +: 4] = host_mode_i ? ldata_q[c] :
                        (lvl[SI_IMP] ? LINE_120 : LINE_75);
      uni_mask[c] = (mode_q[c] == MODE_UNIPOLAR);
    end
  end
  assign pd_mask = pd_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ready_q) begin
      mode_q    <= '{default: MODE_BIPOLAR};
      hi_cnt_q  <= '{default: '0};
      lo_cnt_q  <= '{default: '0};
      hi_ref_q  <= '{default: '0};
      lo_ref_q  <= '{default: '0};
      ubs_q     <= '{default: '0};
      enc_q     <= '{default: 8'h00};
      par_q     <= '0;
      pol_q     <= '0;
      aos_pol_q <= '0;
      pd_q      <= '0;
      aos_q     <= '0;
      a_q       <= '0;
      b_q       <= '0;
    end else begin
      mode_q    <= mode_d;
      hi_cnt_q  <= hi_cnt_d;
      lo_cnt_q  <= lo_cnt_d;
      hi_ref_q  <= hi_ref_d;
      lo_ref_q  <= lo_ref_d;
      ubs_q     <= ubs_d;
      enc_q     <= enc_d;
      par_q     <= par_d;
      pol_q     <= pol_d;
      aos_pol_q <= aos_pol_d;
      pd_q      <= pd_d;
      aos_q     <= aos_d;
      a_q       <= a_d & ~oen_d;
      b_q       <= b_d & ~oen_d;
    end
    if (rst_i) begin
      oen_q <= '1;
      set_q <= '0;
    end else begin
      oen_q <= oen_d;
      set_q <= set_d;
    end
  end

  assign line_out_a_o        = a_q;
  assign line_out_b_o        = b_q;
  assign line_out_en_n_o     = oen_q;
  assign line_setting_code_o = set_q;
  assign ready_o             = ready_q;
  assign wb_dat_o            = dat_q;
  assign wb_ack_o            = ack_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_global_tx_output_control_forces_hiz: assert property (
    global_tx_output_control |=> (line_out_en_n_o == 8'hff))
    else $error("global control did not force hi-z");
  a_global_tx_output_control_keeps_reg: assert property (
    (global_tx_output_control && ready_q && !wr) |=> $stable(outdis_q))
    else $error("disable register moved under global control");
  a_host_disable: assert property (
    (host_mode_i && outdis_q[0]) |=> line_out_en_n_o[0])
    else $error("host disable bit ignored");
  a_bipolar_sample: assert property (
    (fall[SI_TX_LINE_CLOCK] && mode_q[0] == MODE_BIPOLAR && !aos_q[0] && !oen_d[0])
    |=> (line_out_a_o[0] == $past(lvl[SI_TX_POSITIVE_DATA]) &&
         line_out_b_o[0] == $past(lvl[SI_TX_NEGATIVE_DATA])))
    else $error("bipolar rails not sampled on clock fall");
  a_unipolar_entry: assert property (
    (ready_q && mode_q[0] == MODE_BIPOLAR && ubs_q[0] == 12'h010 &&
     fall[SI_TX_LINE_CLOCK] && lvl[SI_TX_NEGATIVE_DATA] && !(!ref_act_q && lvl[SI_TX_LINE_CLOCK]))
    |=> mode_q[0] == MODE_UNIPOLAR)
    else $error("unipolar not entered after 17 clocks");
  a_rz_entry: assert property (
    (ready_q && !ref_act_q && lvl[SI_TX_LINE_CLOCK] && hi_cnt_q[0] >= 12'h960)
    |=> mode_q[0] == MODE_RZ)
    else $error("rz mode not entered");
  a_pd_entry: assert property (
    (ready_q && !lvl[SI_TX_LINE_CLOCK] && lo_ref_q[0] >= 12'h08c && !rise[SI_TX_LINE_CLOCK])
    |=> ##1 line_out_en_n_o[0])
    else $error("idle clock did not power down");
  a_ack_on_ref: assert property (
    $rose(wb_ack_o) |-> $past(ref_rise || !ref_act_q))
    else $error("bus answer not timed by reference");
  a_ready_hiz: assert property (
    !ready_q |=> line_out_en_n_o == 8'hff)
    else $error("drivers active during calibration");

  c_unipolar: cover property ($rose(mode_q[0] == MODE_UNIPOLAR));
  c_rz:       cover property ($rose(mode_q[0] == MODE_RZ));
  c_all_ones: cover property ($rose(aos_q[0]));
  c_bus_wr:   cover property (wr && idx == IDX_LINE_DATA);

endmodule
`default_nettype wire

// File: bench/etf_framer_model.sv
// framer model driving the eight transmit clock and data rail pairs
`default_nettype none
module etf_framer_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] run_i,
  input  wire logic [7:0] idle_lvl_i,
  input  wire logic [7:0] pos_i,
  input  wire logic [7:0] neg_i,
  output logic      [7:0] tx_line_clock_o,
  output logic      [7:0] tx_positive_data_o,
  output logic      [7:0] tx_negative_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // free link clock of 64 ns, phase unrelated to clk_i
  logic lclk;
  initial begin
    // rails start unknown; the first link rise still lands inside reset
    lclk = 1'b0;
    #3.7;
    forever #32 lclk = ~lclk;
  end
  // ==========================================================
  // rails launch on the rising clock so they are steady at the fall;
  // a stopped clock passes the rails straight on for return-to-zero use
  always @(posedge clk_i) begin
    for (int c = 0; c < 8; c++) begin
      tx_line_clock_o[c] <= run_i[c] ? lclk : idle_lvl_i[c];
      if (!run_i[c] || (lclk && !tx_line_clock_o[c])) begin
        tx_positive_data_o[c] <= pos_i[c];
        tx_negative_data_o[c] <= neg_i[c];
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/etf_tx_format_test.sv
// self-checking bench for the e1 transmit format block
`default_nettype none
module etf_tx_format_test
  import etf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 20;
  // ==========================================================
  // stimulus and observed signals
  logic        clk, rst, host, gctl, csel_pin, imp, ref_on;
  logic        ref_clk = 1'b0;
  int          rcnt = 0;
  logic        cyc, stb, we, ack, ready;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, code;
  logic [7:0]  run, idle, pos, neg, tx_line_clock, tx_positive_data, tx_negative_data, la, lb, en_n;
  int          fails, n_checks;

  etf_framer_model framer (.clk_i(clk), .run_i(run), .idle_lvl_i(idle),
    .pos_i(pos), .neg_i(neg), .tx_line_clock_o(tx_line_clock),
    .tx_positive_data_o(tx_positive_data), .tx_negative_data_o(tx_negative_data));

  etf_tx_format #(.CAL_CYCLES(CAL)) dut (.clk_i(clk), .rst_i(rst),
    .host_mode_i(host), .tx_line_clock_i(tx_line_clock), .tx_positive_data_i(tx_positive_data),
    .tx_negative_data_i(tx_negative_data), .ref_clock_i(ref_clk),
    .global_tx_output_control_i(gctl), .line_code_select_i(csel_pin),
    .impedance_select_i(imp), .line_out_a_o(la), .line_out_b_o(lb),
    .line_out_en_n_o(en_n), .line_setting_code_o(code), .ready_o(ready),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // reference near 2.048 MHz, held low while switched off
  always @(posedge clk) begin
    rcnt <= (rcnt == 48) ? 0 : rcnt + 1;
    if (rcnt == 48) ref_clk <= ref_on ? ~ref_clk : 1'b0;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00};
    wdat <= {24'h0, d}; sel <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 400);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    chk(n < 400, 1, "bus answer");
  endtask
  // gathers marks seen on a channel and marks on both rails at once
  task automatic scan(input int ch, output logic [2:0] r);
    r = 3'b000;
    repeat (400) begin
      @(posedge clk);
      r |= {la[ch], lb[ch], la[ch] & lb[ch]};
    end
  endtask
  task automatic do_reset(input logic hm);
    int n;
    n = 0;
    host <= hm;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    chk({en_n, la, lb, ready}, {8'hff, 16'h0, 1'b0}, "reset");
    rst <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 100);
    chk(n >= CAL && n <= CAL + 3, 1, "ready time");
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    wb(1, IDX_CHAN_SEL, 8'h01, q);
    wb(1, IDX_LINE_DATA, {4'h0, LINE_120}, q);
    wb(1, IDX_CHAN_SEL, 8'h00, q);
    wb(1, IDX_LINE_DATA, {4'h0, LINE_75}, q);
    // the setting output lags the register by one more clock
    repeat (2) @(posedge clk);
    chk(code[7:0], {LINE_120, LINE_75}, "mixed lines");
    chk(code[31:8], 24'h0, "pin ignored in host");
    wb(1, IDX_CHAN_SEL, 8'h01, q);
    wb(0, IDX_LINE_DATA, 8'h00, q);
    chk(q[3:0], LINE_120, "line data read");
    wb(0, 8'h20, 8'h00, q);
    chk(q, 32'h0, "unmapped read");
    wb(0, IDX_STATUS, 8'h00, q);
    chk(q[1:0], 2'b11, "status");
  endtask
  task automatic t_bipolar();
    pos <= 8'h01;
    repeat (300) @(posedge clk);
    chk({la[0], lb[0], en_n[0]}, 3'b100, "bipolar positive");
    pos <= 8'h00;
    neg <= 8'h01;
    repeat (60) @(posedge clk);
    chk({la[0], lb[0]}, 2'b01, "bipolar negative");
    neg <= 8'h00;
  endtask
  task automatic t_unipolar();
    logic [31:0] q;
    logic [2:0]  r;
    neg <= 8'h21;
    repeat (400) @(posedge clk);
    wb(0, IDX_CHAN_STATE, 8'h00, q);
    chk(q[7:0], 8'h21, "unipolar entered");
    scan(0, r);
    chk(r, 3'b000, "ami zeros");
    wb(1, IDX_CHAN_SEL, 8'h10, q);
    repeat (100) @(posedge clk);
    scan(0, r);
    chk(r, 3'b110, "hdb3 ch0");
    scan(5, r);
    chk(r, 3'b110, "hdb3 ch5");
    wb(1, IDX_CHAN_SEL, 8'h00, q);
    pos <= 8'h01;
    repeat (100) @(posedge clk);
    scan(0, r);
    chk(r, 3'b110, "ami ones");
    pos <= 8'h00;
    neg <= 8'h00;
    repeat (100) @(posedge clk);
    wb(0, IDX_CHAN_STATE, 8'h00, q);
    chk(q[7:0], 8'h00, "back to bipolar");
  endtask
  task automatic t_disable();
    logic [31:0] q;
    int n;
    n = 0;
    wb(1, IDX_OUT_DIS, 8'h04, q);
    repeat (10) @(posedge clk);
    chk(en_n, 8'h04, "channel disable");
    gctl <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (en_n !== 8'hff && n < 300);
    chk(n <= 200, 1, "global hi-z time");
    chk({la, lb}, 16'h0, "quiet in hi-z");
    wb(0, IDX_OUT_DIS, 8'h00, q);
    chk(q[7:0], 8'h04, "disable kept");
    gctl <= 1'b0;
    wb(1, IDX_OUT_DIS, 8'h00, q);
    repeat (20) @(posedge clk);
    chk(en_n, 8'h00, "all driving");
  endtask
  task automatic t_pdown();
    logic [31:0] q;
    run <= 8'hf7;
    repeat (2500) @(posedge clk);
    wb(0, IDX_CHAN_STATE, 8'h00, q);
    chk({en_n[3], q[15:8]}, {1'b1, 8'h08}, "power down");
    run <= 8'hff;
    repeat (50) @(posedge clk);
    chk(en_n[3], 1'b0, "power up again");
  endtask
  task automatic t_rz();
    ref_on <= 1'b0;
    run <= 8'hfb;
    idle <= 8'h04;
    repeat (2800) @(posedge clk);
    pos <= 8'h04;
    repeat (12) @(posedge clk);
    chk({la[2], lb[2], en_n[2]}, 3'b100, "rz positive");
    pos <= 8'h00;
    neg <= 8'h04;
    repeat (12) @(posedge clk);
    chk({la[2], lb[2]}, 2'b01, "rz negative");
    neg <= 8'h00;
    ref_on <= 1'b1;
    run <= 8'hff;
    idle <= 8'h00;
    repeat (300) @(posedge clk);
  endtask
  task automatic t_hw();
    logic [31:0] q;
    logic [2:0]  r;
    wb(1, IDX_CHAN_SEL, 8'h05, q);
    do_reset(1'b0);
    wb(0, IDX_CHAN_SEL, 8'h00, q);
    chk(q[7:0], CSEL_RST, "select reset");
    chk(code, {8{LINE_120}}, "pin 120");
    imp <= 1'b0;
    repeat (20) @(posedge clk);
    chk(code, {8{LINE_75}}, "pin 75");
    // hardware mode: the code pin picks the unipolar encoding
    neg <= 8'h01;
    repeat (400) @(posedge clk);
    scan(0, r);
    chk(r, 3'b110, "pin hdb3");
    csel_pin <= 1'b0;
    repeat (100) @(posedge clk);
    scan(0, r);
    chk(r, 3'b000, "pin ami");
    neg <= 8'h00;
    repeat (100) @(posedge clk);
    run <= 8'hef;
    idle <= 8'h10;
    repeat (2000) @(posedge clk);
    scan(4, r);
    chk(r, 3'b110, "all ones");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    fails = 0; n_checks = 0; ref_on = 1'b1;
    rst = 1'b1; host = 1'b1; gctl = 1'b0; csel_pin = 1'b1; imp = 1'b1;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 10'h0; sel = 4'h0;
    wdat = 32'h0; run = 8'hff; idle = 8'h00; pos = 8'h00; neg = 8'h00;
    do_reset(1'b1);
    t_regs();
    t_bipolar();
    t_unipolar();
    t_disable();
    t_pdown();
    t_rz();
    t_hw();
    report_and_stop();
  end
  // the run needs some 13000 cycles; a hang is cut off well after that
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
